// *** axis_analog_pkg.sv ***
// Package for the axis analog register interface: byte map, field layouts, timing.
// Assumes a byte-wide controller interface with byte index 0..7 and one 100 MHz clock.
package axis_analog_pkg;

  // Interface byte indices
  localparam logic [2:0] BYTE_SELECT   = 3'h0;
  localparam logic [2:0] BYTE_LOW_1    = 3'h1;
  localparam logic [2:0] BYTE_LOW_2    = 3'h2;
  localparam logic [2:0] BYTE_LOW_3    = 3'h3;
  localparam logic [2:0] BYTE_START    = 3'h4;
  localparam logic [2:0] BYTE_HIGH_5   = 3'h5;
  localparam logic [2:0] BYTE_HIGH_6   = 3'h6;
  localparam logic [2:0] BYTE_HIGH_7   = 3'h7;

  // Selection byte fields
  localparam int SEL_MODULE_LSB = 0;
  localparam int SEL_REG_LSB    = 3;
  localparam int SEL_RESET_BIT  = 6;

  // Module codes
  localparam logic [2:0] MODULE_ONE = 3'h6;
  localparam logic [2:0] MODULE_TWO = 3'h7;

  // Register codes
  localparam logic [2:0] REG_ADDITIONAL = 3'h6;
  localparam logic [2:0] REG_NONE       = 3'h7;

  // Numeric register codes on the main module
  localparam logic [2:0] NUM_MODULO    = 3'h0;
  localparam logic [2:0] NUM_PRECUT    = 3'h1;
  localparam logic [2:0] NUM_ACTUAL    = 3'h2;
  localparam logic [2:0] NUM_REFERENCE = 3'h0;
  localparam logic [2:0] NUM_ZERO_OFS  = 3'h1;
  localparam logic [2:0] NUM_CUTOFF    = 3'h2;
  localparam logic [2:0] NUM_GATE      = 3'h3;

  // Command register bits
  localparam int CMD_ANALOG    = 0;
  localparam int CMD_NEG_SETPT = 1;
  localparam int CMD_TEST      = 2;
  localparam int CMD_BRAKE_POL = 3;

  // Widths
  localparam int NUM_W     = 24;
  localparam int RAMP_W    = 12;
  localparam int SPEED_W   = 11;
  localparam int ADD_W     = 12;
  localparam int CMD_W     = 4;
  localparam int AXES      = 6;

  // Reset values
  localparam logic [7:0] SELECT_RESET = 8'h00;

  // Ramp pause timing
  localparam int CLK_PERIOD_PS   = 10000;
  localparam int PAUSE_NORMAL_PS = 1000000000;
  localparam int PAUSE_TEST_PS   = 500000;
  localparam int PAUSE_NORMAL_CYC = PAUSE_NORMAL_PS / CLK_PERIOD_PS;
  localparam int PAUSE_TEST_CYC   = PAUSE_TEST_PS / CLK_PERIOD_PS;

  typedef struct packed {
    logic [2:0] index;
    logic [7:0] data;
  } byte_access_s;

  typedef struct packed {
    logic [RAMP_W-1:0]  accelRamp;
    logic [RAMP_W-1:0]  brakeRamp;
    logic [SPEED_W-1:0] rapidValue;
    logic [SPEED_W-1:0] slowValue;
    logic [CMD_W-1:0]   command;
  } axis_cfg_s;

endpackage

// *** axis_analog_register_interface.sv ***
// Byte-wide register interface of a multi-axis positioning module with two analog modules.
// Assumes the controller writes bytes synchronously to sys_clk, one byte per strobe.
// Summary of operation
// - Numeric register is three bytes addressed together, chosen by selection byte.
// - Numeric registers hold unsigned 24-bit counts from zero to all ones.
// - Reference, offset, cutoff, gate in bytes 5-7; modulo, pre-cutoff, actual in 1-3.
// - Analog module registers are write-only; target chosen first in byte zero.
// - Selection bit six low clears numeric, start/stop and analog registers.
// - Module code 110 serves axes one to three, 111 axes four to six.
// - First selection of absent module gets no acknowledge, nor do later analog ones; after a present one first, all acknowledge.
// - Even codes: acceleration ramp bytes 1-2, command byte 3, brake ramp bytes 5-6.
// - Odd codes: rapid value bytes 1-2, slow value bytes 5-6.
// - Code 110 selects additional analog value; code 111 selects nothing.
// - Values little-endian: first byte holds the least significant bits.
// - Analog modules raise no interrupts.
// - Start and stop go through byte four; each axis has its own command.
// - Command bit zero selects analog mode with enable and brake outputs.
// - Command bit one allows negative setpoints when moving backward.
// - Command bit two picks ramp pause of one millisecond or half microsecond.
// - Command bit three inverts brake polarity; bits seven to four unused.
// - Hardware reset clears all registers and outputs to zero.
// - Ramp registers hold 12 bits, upper four of second byte unused.
// - Rapid and slow registers hold 11 bits, upper five of second byte unused.
module axis_analog_register_interface (
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           rst_n,
  // Controller byte interface
  input  wire logic                           wrStrobe,
  input  wire logic                           rdStrobe,
  input  wire axis_analog_pkg::byte_access_s  hostAccess,
  output logic [7:0]                          rdData,
  output logic                                ackOut,
  // Module presence and axis activity
  input  wire logic [1:0]                     modulePresent,
  input  wire logic [axis_analog_pkg::AXES-1:0] axisPositioning,
  // Per-axis outputs
  output logic [7:0]                          startStop,
  output logic [axis_analog_pkg::AXES-1:0]    analogMode,
  output logic [axis_analog_pkg::AXES-1:0]    negativeSetpoint,
  output logic [axis_analog_pkg::AXES-1:0]    brakeOut,
  output logic [axis_analog_pkg::AXES-1:0]    pauseTick,
  output axis_analog_pkg::axis_cfg_s [axis_analog_pkg::AXES-1:0] axisCfg,
  output logic [axis_analog_pkg::ADD_W-1:0]   additionalValue [2],
  output logic                                irqOut
);

  localparam int NW = axis_analog_pkg::NUM_W;
  localparam int NA = axis_analog_pkg::AXES;

  logic [7:0]    select_r;
  logic [NW-1:0] lowRegs_r  [3];
  logic [NW-1:0] highRegs_r [4];
  logic          firstSelDone_r;
  logic          ackBlocked_r;
  logic          softClear;
  logic [2:0]    moduleCode;
  logic [2:0]    regCode;
  logic          analogSel;
  logic          moduleIdx;

  // Bytes 1..3 or 5..7 map to a byte lane 0..2 of a numeric register
  function automatic logic [1:0] laneOf(input logic [2:0] idx);
    logic [1:0] lane;
    lane = (idx >= axis_analog_pkg::BYTE_HIGH_5) ? 2'(idx - axis_analog_pkg::BYTE_HIGH_5)
                                                  : 2'(idx - axis_analog_pkg::BYTE_LOW_1);
    return lane;
  endfunction

  assign softClear  = wrStrobe && hostAccess.index == axis_analog_pkg::BYTE_SELECT
                      && !hostAccess.data[axis_analog_pkg::SEL_RESET_BIT];
  assign moduleCode = select_r[axis_analog_pkg::SEL_MODULE_LSB +: 3];
  assign regCode    = select_r[axis_analog_pkg::SEL_REG_LSB +: 3];
  assign analogSel  = moduleCode == axis_analog_pkg::MODULE_ONE
                      || moduleCode == axis_analog_pkg::MODULE_TWO;
  assign moduleIdx  = moduleCode == axis_analog_pkg::MODULE_TWO;

  // Selection byte
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      select_r <= axis_analog_pkg::SELECT_RESET;
    end else if (wrStrobe && hostAccess.index == axis_analog_pkg::BYTE_SELECT) begin
      select_r <= hostAccess.data;
    end
  end

  // Numeric registers, three bytes each, little-endian lanes
  always_ff @(posedge sys_clk) begin
    if (!rst_n || softClear) begin
      for (int i = 0; i < 3; i++) lowRegs_r[i] <= '0;
      for (int i = 0; i < 4; i++) highRegs_r[i] <= '0;
    end else if (wrStrobe && !analogSel) begin
      if (hostAccess.index inside {[axis_analog_pkg::BYTE_LOW_1:axis_analog_pkg::BYTE_LOW_3]}
          && regCode <= axis_analog_pkg::NUM_ACTUAL) begin
        lowRegs_r[regCode[1:0]][laneOf(hostAccess.index)*8 +: 8] <= hostAccess.data;
      end else if (hostAccess.index >= axis_analog_pkg::BYTE_HIGH_5
                   && regCode <= axis_analog_pkg::NUM_GATE) begin
        highRegs_r[regCode[1:0]][laneOf(hostAccess.index)*8 +: 8] <= hostAccess.data;
      end
    end
  end

  // Read path: numeric registers only; analog registers return nothing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else if (rdStrobe) begin
      rdData <= 8'h00;
      if (!analogSel) begin
        if (hostAccess.index inside {[axis_analog_pkg::BYTE_LOW_1:axis_analog_pkg::BYTE_LOW_3]}
            && regCode <= axis_analog_pkg::NUM_ACTUAL) begin
          rdData <= lowRegs_r[regCode[1:0]][laneOf(hostAccess.index)*8 +: 8];
        end else if (hostAccess.index >= axis_analog_pkg::BYTE_HIGH_5
                     && regCode <= axis_analog_pkg::NUM_GATE) begin
          rdData <= highRegs_r[regCode[1:0]][laneOf(hostAccess.index)*8 +: 8];
        end
      end
    end
  end

  // Acknowledge: an absent module selected first after power-up blocks it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      firstSelDone_r <= 1'b0;
      ackBlocked_r   <= 1'b0;
    end else if (!firstSelDone_r && analogSel && (wrStrobe || rdStrobe)
                 && hostAccess.index != axis_analog_pkg::BYTE_SELECT) begin
      firstSelDone_r <= 1'b1;
      ackBlocked_r   <= !modulePresent[moduleIdx];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ackOut <= 1'b0;
    end else begin
      ackOut <= (wrStrobe || rdStrobe) && !(analogSel && ackBlocked_r)
                && !(analogSel && !firstSelDone_r && !modulePresent[moduleIdx]
                     && hostAccess.index != axis_analog_pkg::BYTE_SELECT);
    end
  end

  // Start/stop byte belongs to the main module, not the analog registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n || softClear) begin
      startStop <= 8'h00;
    end else if (wrStrobe && hostAccess.index == axis_analog_pkg::BYTE_START) begin
      startStop <= hostAccess.data;
    end
  end

  // Analog module registers, per axis
  generate
    for (genvar a = 0; a < NA; a++) begin : g_axis
      localparam logic       MOD  = (a >= 3);
      localparam logic [2:0] EVEN = 3'(2 * (a % 3));
      localparam logic [2:0] ODD  = 3'(2 * (a % 3) + 1);
      logic hit;
      logic [31:0] pauseCnt_r;
      logic [31:0] pauseLimit;

      assign hit = wrStrobe && analogSel && moduleIdx == MOD && modulePresent[MOD];

      always_ff @(posedge sys_clk) begin
        if (!rst_n || softClear) begin
          axisCfg[a] <= '0;
        end else if (hit && regCode == EVEN) begin
          unique case (hostAccess.index)
            axis_analog_pkg::BYTE_LOW_1:  axisCfg[a].accelRamp[7:0]  <= hostAccess.data;
            axis_analog_pkg::BYTE_LOW_2:  axisCfg[a].accelRamp[11:8] <= hostAccess.data[3:0];
            axis_analog_pkg::BYTE_LOW_3:  axisCfg[a].command <= hostAccess.data[3:0];
            axis_analog_pkg::BYTE_HIGH_5: axisCfg[a].brakeRamp[7:0]  <= hostAccess.data;
            axis_analog_pkg::BYTE_HIGH_6: axisCfg[a].brakeRamp[11:8] <= hostAccess.data[3:0];
            default: ;
          endcase
        end else if (hit && regCode == ODD) begin
          unique case (hostAccess.index)
            axis_analog_pkg::BYTE_LOW_1:  axisCfg[a].rapidValue[7:0]  <= hostAccess.data;
            axis_analog_pkg::BYTE_LOW_2:  axisCfg[a].rapidValue[10:8] <= hostAccess.data[2:0];
            axis_analog_pkg::BYTE_HIGH_5: axisCfg[a].slowValue[7:0]   <= hostAccess.data;
            axis_analog_pkg::BYTE_HIGH_6: axisCfg[a].slowValue[10:8]  <= hostAccess.data[2:0];
            default: ;
          endcase
        end
      end

      // Output stages derived from the command bits
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          analogMode[a]       <= 1'b0;
          negativeSetpoint[a] <= 1'b0;
          brakeOut[a]         <= 1'b0;
        end else begin
          analogMode[a]       <= axisCfg[a].command[axis_analog_pkg::CMD_ANALOG];
          negativeSetpoint[a] <= axisCfg[a].command[axis_analog_pkg::CMD_NEG_SETPT];
          // Brake only meaningful in analog mode; held low otherwise
          brakeOut[a] <= axisCfg[a].command[axis_analog_pkg::CMD_ANALOG]
                         && (axisPositioning[a]
                             ^ axisCfg[a].command[axis_analog_pkg::CMD_BRAKE_POL]);
        end
      end

      // Ramp pause tick; the half-microsecond setting is a test speed-up
      assign pauseLimit = axisCfg[a].command[axis_analog_pkg::CMD_TEST]
                          ? 32'(axis_analog_pkg::PAUSE_TEST_CYC - 1)
                          : 32'(axis_analog_pkg::PAUSE_NORMAL_CYC - 1);

      always_ff @(posedge sys_clk) begin
        if (!rst_n || !axisCfg[a].command[axis_analog_pkg::CMD_ANALOG]) begin
          pauseCnt_r   <= 32'h0;
          pauseTick[a] <= 1'b0;
        end else if (pauseCnt_r >= pauseLimit) begin
          pauseCnt_r   <= 32'h0;
          pauseTick[a] <= 1'b1;
        end else begin
          pauseCnt_r   <= pauseCnt_r + 32'h1;
          pauseTick[a] <= 1'b0;
        end
      end
    end
  endgenerate

  // Additional analog value per module, sign in bit 11
  generate
    for (genvar m = 0; m < 2; m++) begin : g_module
      always_ff @(posedge sys_clk) begin
        if (!rst_n || softClear) begin
          additionalValue[m] <= '0;
        end else if (wrStrobe && analogSel && moduleIdx == 1'(m) && modulePresent[m]
                     && regCode == axis_analog_pkg::REG_ADDITIONAL) begin
          if (hostAccess.index == axis_analog_pkg::BYTE_LOW_1) begin
            additionalValue[m][7:0] <= hostAccess.data;
          end else if (hostAccess.index == axis_analog_pkg::BYTE_LOW_2) begin
            additionalValue[m][11:8] <= hostAccess.data[3:0];
          end
        end
      end
    end
  endgenerate

  // Analog modules never interrupt
  always_ff @(posedge sys_clk) begin
    irqOut <= 1'b0;
  end

endmodule

// *** axis_analog_register_interface_asserts.sv ***
// Checker for the axis analog register interface, watching its ports only.
// Assumes one sys_clk domain and a synchronous active-low rst_n.
module axis_analog_register_interface_asserts (
  // Clock and reset
  input wire logic                             sys_clk,
  input wire logic                             rst_n,
  // Controller byte interface
  input wire logic                             wrStrobe,
  input wire logic                             rdStrobe,
  input wire axis_analog_pkg::byte_access_s    hostAccess,
  input wire logic [7:0]                       rdData,
  input wire logic                             ackOut,
  // Axis side
  input wire logic [1:0]                       modulePresent,
  input wire logic [5:0]                       axisPositioning,
  input wire logic [7:0]                       startStop,
  input wire logic [5:0]                       analogMode,
  input wire logic [5:0]                       negativeSetpoint,
  input wire logic [5:0]                       brakeOut,
  input wire logic [5:0]                       pauseTick,
  input wire axis_analog_pkg::axis_cfg_s [5:0] axisCfg,
  input wire logic [11:0]                      additionalValue [2],
  input wire logic                             irqOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_ack_cause; ackOut |-> $past(wrStrobe || rdStrobe); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without strobe");
  property p_ack_end; !(wrStrobe || rdStrobe) |=> !ackOut; endproperty
  a_ack_end: assert property (p_ack_end) else $error("ack too long");
  property p_no_irq; irqOut == 1'b0; endproperty
  a_no_irq: assert property (p_no_irq) else $error("interrupt raised");
  property p_reset; $rose(rst_n) |-> startStop == 8'h00 && analogMode == 6'h00; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared");
  property p_start;
    wrStrobe && hostAccess.index == axis_analog_pkg::BYTE_START
      |=> startStop == $past(hostAccess.data);
  endproperty
  a_start: assert property (p_start) else $error("start byte lost");
  property p_clear;
    wrStrobe && hostAccess.index == axis_analog_pkg::BYTE_SELECT && !hostAccess.data[6]
      |=> startStop == 8'h00 && axisCfg == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear bit ignored");
  // A one-cycle lag after leaving analog mode is tolerated
  property p_brake; (brakeOut & ~analogMode & ~$past(analogMode)) == 6'h00; endproperty
  a_brake: assert property (p_brake) else $error("brake in digital mode");
  property p_cfg; !wrStrobe |=> $stable(axisCfg); endproperty
  a_cfg: assert property (p_cfg) else $error("config changed without write");
  property p_tick; pauseTick[0] |=> !pauseTick[0]; endproperty
  a_tick: assert property (p_tick) else $error("pause tick too long");
  c_start: cover property (wrStrobe && hostAccess.index == axis_analog_pkg::BYTE_START);
  c_brake: cover property (brakeOut[0]);
  c_tick: cover property (pauseTick[0]);
endmodule
bind axis_analog_register_interface axis_analog_register_interface_asserts chk (.*);

// *** axis_ctrl_model.sv ***
// Controller model issuing single-byte transfers on the byte interface.
// Assumes the bench calls its tasks; strobes change on falling sys_clk edges.
module axis_ctrl_model (
  // Clock
  input wire logic                     sys_clk,
  // Byte interface
  output logic                         wrStrobe,
  output logic                         rdStrobe,
  output axis_analog_pkg::byte_access_s hostAccess,
  input wire logic [7:0]               rdData,
  input wire logic                     ackOut
);
  initial begin
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    hostAccess = '0;
  end
  // Idle data is inverted so a stale byte never passes for a fresh one
  task automatic xfer(input logic rd, input logic [2:0] idx, input logic [7:0] d,
                      output logic ack, output logic [7:0] q);
    @(negedge sys_clk);
    wrStrobe = !rd;
    rdStrobe = rd;
    hostAccess = '{index: idx, data: d};
    @(negedge sys_clk);
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    ack = ackOut;
    q = rdData;
    hostAccess.data = ~d;
  endtask
  // Selection byte always precedes data and keeps the clear bit high
  task automatic sel(input logic [2:0] r, input logic [2:0] m, output logic ack);
    logic [7:0] q;
    xfer(1'b0, 3'h0, {2'b01, r, m}, ack, q);
  endtask
endmodule

// *** axis_analog_register_interface_test.sv ***
// Self-checking bench for the axis analog register interface.
// Assumes the controller model drives strobes on falling edges of sys_clk.
module axis_analog_register_interface_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                             sys_clk, rst_n, wrStrobe, rdStrobe, ackOut, irqOut, ack;
  axis_analog_pkg::byte_access_s    hostAccess;
  logic [7:0]                       rdData, startStop, q;
  logic [1:0]                       modulePresent;
  logic [5:0]                       axisPositioning, analogMode, negativeSetpoint;
  logic [5:0]                       brakeOut, pauseTick;
  axis_analog_pkg::axis_cfg_s [5:0] axisCfg, snap;
  logic [11:0]                      additionalValue [2];
  logic [23:0]                      v, w;
  logic [2:0]                       r, m;
  int                               fails, checked, seed, n, ax;
  axis_analog_register_interface DUT (.*);
  axis_ctrl_model ctrl (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    ctrl.xfer(1'b0, idx, d, ack, q);
  endtask
  task automatic hw_reset(input logic [1:0] pres);
    @(negedge sys_clk);
    rst_n = 1'b0;
    modulePresent = pres;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
  endtask
  task automatic complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    complete_run();
  end
  initial begin
    fails = 0;
    checked = 0;
    seed = 32'h20eccc97;
    rst_n = 1'b0;
    modulePresent = 2'h3;
    axisPositioning = 6'h00;
    hw_reset(2'h3);
    cmp("startStop", 24'h0, startStop);
    cmp("analogMode", 24'h0, analogMode);
    cmp("irqOut", 24'h0, irqOut);
    for (ax = 0; ax < 6; ax++) begin
      r = 3'((ax % 3) * 2);
      m = (ax < 3) ? 3'h6 : 3'h7;
      v = 24'($random(seed));
      ctrl.sel(r, m, ack);
      wr(3'h1, v[7:0]);
      wr(3'h2, v[15:8]);
      wr(3'h5, v[15:8]);
      wr(3'h6, v[7:0]);
      wr(3'h3, v[7:0]);
      wr(3'h7, 8'hFF);
      cmp("accelRamp", {v[11:8], v[7:0]}, axisCfg[ax].accelRamp);
      cmp("brakeRamp", {v[3:0], v[15:8]}, axisCfg[ax].brakeRamp);
      cmp("command", v[3:0], axisCfg[ax].command);
      cmp("analogMode", v[0], analogMode[ax]);
      cmp("negativeSetpoint", v[1], negativeSetpoint[ax]);
      ctrl.sel(r + 3'h1, m, ack);
      wr(3'h1, v[23:16]);
      wr(3'h2, v[7:0]);
      wr(3'h5, v[15:8]);
      wr(3'h6, v[23:16]);
      wr(3'h7, 8'hFF);
      cmp("rapidValue", {v[2:0], v[23:16]}, axisCfg[ax].rapidValue);
      cmp("slowValue", {v[18:16], v[15:8]}, axisCfg[ax].slowValue);
    end
    for (ax = 0; ax < 2; ax++) begin
      v = 24'($random(seed));
      ctrl.sel(3'h6, 3'(6 + ax), ack);
      wr(3'h1, v[7:0]);
      wr(3'h2, v[15:8]);
      wr(3'h5, 8'hFF);
      cmp("additionalValue", {v[11:8], v[7:0]}, additionalValue[ax]);
    end
    snap = axisCfg;
    ctrl.sel(3'h7, 3'h6, ack);
    for (ax = 1; ax < 8; ax++)
      if (ax != 4)
        wr(3'(ax), 8'($random(seed)));
    cmp("unassignedCode", 24'h1, {23'h0, axisCfg === snap});
    v = 24'($random(seed));
    wr(3'h4, v[7:0]);
    cmp("startStop", v[7:0], startStop);
    for (ax = 0; ax < 2; ax++) begin
      v = 24'($random(seed));
      ctrl.sel(ax ? 3'h3 : 3'h0, 3'h0, ack);
      for (n = 0; n < 3; n++)
        wr(3'(1 + 4 * ax + n), v[8 * n +: 8]);
      for (n = 0; n < 3; n++) begin
        ctrl.xfer(1'b1, 3'(1 + 4 * ax + n), 8'h00, ack, q);
        w[8 * n +: 8] = q;
      end
      cmp("numericValue", v, w);
    end
    ctrl.sel(3'h0, 3'h6, ack);
    ctrl.xfer(1'b1, 3'h1, 8'h00, ack, q);
    cmp("analogRead", 24'h0, q);
    wr(3'h3, 8'h01);
    axisPositioning = 6'h01;
    repeat (3) @(negedge sys_clk);
    cmp("brakeOut", 24'h1, brakeOut[0]);
    axisPositioning = 6'h00;
    repeat (3) @(negedge sys_clk);
    cmp("brakeOut", 24'h0, brakeOut[0]);
    wr(3'h3, 8'h0D);
    n = 0;
    repeat (500) begin
      @(negedge sys_clk);
      n += pauseTick[0];
    end
    cmp("brakeOut", 24'h1, brakeOut[0]);
    cmp("pauseTicks", 24'd10, 24'(n));
    wr(3'h3, 8'h08);
    wr(3'h7, 8'h00);
    cmp("brakeOut", 24'h0, brakeOut[0]);
    wr(3'h0, 8'h06);
    cmp("clearCfg", 24'h1, {23'h0, axisCfg === '0});
    cmp("clearStart", 24'h0, startStop);
    cmp("irqOut", 24'h0, irqOut);
    hw_reset(2'h1);
    ctrl.sel(3'h0, 3'h7, ack);
    wr(3'h1, 8'h55);
    cmp("absentAck", 24'h0, ack);
    ctrl.sel(3'h0, 3'h6, ack);
    wr(3'h1, 8'h55);
    cmp("blockedAck", 24'h0, ack);
    hw_reset(2'h1);
    ctrl.sel(3'h0, 3'h6, ack);
    wr(3'h1, 8'h55);
    cmp("presentAck", 24'h1, ack);
    ctrl.sel(3'h0, 3'h7, ack);
    wr(3'h1, 8'h55);
    cmp("laterAbsentAck", 24'h1, ack);
    complete_run();
  end
endmodule
